// *** bench/readback_status_event_bank_tb_top.sv ***
// Purpose: directed tests of the readback bank
// Assumes: host model issues reads
// Notes: expectations built from the register map
`timescale 1ns/10ps
module readback_status_event_bank_tb_top;
   logic mclk, rst_n, rx_word_ready, tx_buffer_free, tx_abort_or_arb_lost, tx_encoder_active;
   logic reverse_control_channel_busy, counter_at_zero, audio_if_active;
   logic forward_voice_channel_receiving, forward_control_channel_sync;
   rsevb_pkg::rsevb_band_type supervisory_tone_band;
   logic [11:0] event_pulse;
   logic [7:0] expansion_port_a_pins, expansion_port_b_pins, audio_adc_value, d;
   logic [7:0] supervisory_tone_offset;
   logic [3:0] expansion_port_c_pins, decode_status, vote_repeats;
   logic [27:0] corrected_rx_word;
   logic [39:0] raw_rx_word;
   wire logic rd_en;
   wire logic [6:0] rd_addr;
   wire logic [7:0] rd_data;
   int error_cnt = 0;
   int cmp_count = 0;
   rsevb_bank dut_u (.*);
   rsevb_host host_u (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      host_u.rd(a, d);
      cmp_count++;
      if (d !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED addr %h expected %h seen %h", a, e, d);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic t_status();
      for (int b = 0; b < 4; b++)
      begin
         supervisory_tone_band = rsevb_pkg::rsevb_band_type'(b);
         {counter_at_zero, reverse_control_channel_busy, tx_encoder_active,
            tx_abort_or_arb_lost, tx_buffer_free, rx_word_ready} = 6'h15 ^ {6{b[0]}};
         {forward_control_channel_sync, forward_voice_channel_receiving,
            audio_if_active} = 3'h5 ^ {3{b[0]}};
         rdc(7'h00, {b[1:0], 6'h15 ^ {6{b[0]}}});
         rdc(7'h01, {5'h00, 3'h5 ^ {3{b[0]}}});
         rdc(7'h03, 8'h00);
      end
      $display("status test done");
   endtask
   task automatic t_data();
      corrected_rx_word = 28'h9abcdef;
      decode_status = 4'h5;
      raw_rx_word = 40'h0123456789;
      vote_repeats = 4'ha;
      audio_adc_value = 8'hc3;
      supervisory_tone_offset = 8'hfb;
      for (int i = 0; i < 3; i++)
         rdc(7'h10 + 7'(i), corrected_rx_word[27 - 8 * i -: 8]);
      rdc(7'h13, 8'hf5);
      for (int i = 0; i < 5; i++)
         rdc(7'h18 + 7'(i), raw_rx_word[39 - 8 * i -: 8]);
      rdc(7'h1d, 8'h0a);
      rdc(7'h20, 8'hc3);
      rdc(7'h30, 8'hfb);
      $display("data test done");
   endtask
   task automatic t_events();
      event_pulse = 12'hfff;
      @(posedge mclk);
      #1;
      event_pulse = 12'h000;
      repeat (2) @(posedge mclk);
      #1;
      rdc(7'h02, 8'hff);
      event_pulse = 12'h001;
      fork
         host_u.rd(7'h02, d);
         begin
            @(posedge mclk);
            #1 event_pulse = 12'h000;
         end
      join
      cmp_count++;
      if (d !== 8'h00)
      begin
         error_cnt++;
         $display("CHECK FAILED events after clear expected 00 seen %h", d);
      end
      rdc(7'h02, 8'h01);
      rdc(7'h02, 8'h00);
      $display("event test done");
   endtask
   task automatic t_ports();
      expansion_port_a_pins = 8'ha5;
      expansion_port_b_pins = 8'h3c;
      expansion_port_c_pins = 4'h9;
      repeat (3) @(posedge mclk);
      #1;
      rdc(7'h04, 8'ha5);
      rdc(7'h05, 8'h3c);
      rdc(7'h06, 8'h09);
      $display("port test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      #50000;
      error_cnt++;
      conclude();
   end
   initial
   begin
      rst_n = 1'b0;
      {rx_word_ready, tx_buffer_free, tx_abort_or_arb_lost, tx_encoder_active} = 4'h0;
      {reverse_control_channel_busy, counter_at_zero, audio_if_active} = 3'h0;
      {forward_voice_channel_receiving, forward_control_channel_sync} = 2'h0;
      supervisory_tone_band = rsevb_pkg::rsevb_band_invalid;
      event_pulse = 12'h000;
      {expansion_port_a_pins, expansion_port_b_pins, expansion_port_c_pins} = 20'h00000;
      {corrected_rx_word, decode_status, raw_rx_word, vote_repeats} = 76'h0;
      {audio_adc_value, supervisory_tone_offset} = 16'h0000;
      repeat (4) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_status();
      t_data();
      t_events();
      t_ports();
      conclude();
   end
endmodule

// *** bench/rsevb_bank_sva.sv ***
// Purpose: port checks of the readback bank
// Assumes: rd_data lands one edge after a taken read
// Notes: bound below
`timescale 1ns/10ps
module rsevb_bank_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic rd_en,
   input wire logic [6:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic [11:0] event_pulse,
   input wire logic [27:0] corrected_rx_word,
   input wire logic [3:0] decode_status,
   input wire logic [39:0] raw_rx_word,
   input wire logic [3:0] vote_repeats,
   input wire logic [7:0] audio_adc_value,
   input wire logic [7:0] supervisory_tone_offset
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // a boolean, not a sequence, so it may be combined with && below
   let rd(a) = rd_en && rd_addr == a;
   ////////////////////////////////////////////////////////////////////////////////
   AST_CRX0: assert property (rd(7'h10) |=> rd_data == $past(corrected_rx_word[27:20]))
      else $error("corrected byte 0 wrong");
   AST_TAIL: assert property (rd(7'h13) |=> rd_data ==
      $past({corrected_rx_word[3:0], decode_status})) else $error("tail byte wrong");
   AST_RAW0: assert property (rd(7'h18) |=> rd_data == $past(raw_rx_word[39:32]))
      else $error("raw byte 0 wrong");
   AST_REP: assert property (rd(7'h1d) |=> rd_data == {4'h0, $past(vote_repeats)})
      else $error("repeat count wrong");
   AST_ADC: assert property (rd(7'h20) |=> rd_data == $past(audio_adc_value))
      else $error("adc byte wrong");
   AST_TONE: assert property (rd(7'h30) |=> rd_data == $past(supervisory_tone_offset))
      else $error("tone byte wrong");
   AST_UNMAP: assert property (rd(7'h03) |=> rd_data == 8'h00)
      else $error("unlisted address not zero");
   AST_HOLD: assert property (!rd_en |=> $stable(rd_data)) else $error("read data moved");
   AST_EVT_CLR: assert property (rd(7'h02) && event_pulse == 12'h000
      ##1 event_pulse == 12'h000 ##1 rd(7'h02) |=> rd_data == 8'h00) else $error("not cleared");
   AST_EVT_KEEP: assert property (rd(7'h02) && event_pulse[0]
      ##1 event_pulse == 12'h000 ##1 rd(7'h02) |=> rd_data[0]) else $error("event lost");
   COV_EVT: cover property (rd(7'h02));
   COV_RAW: cover property (rd(7'h1c));
   COV_UNMAP: cover property (rd(7'h03));
endmodule
bind rsevb_bank rsevb_bank_chk chk_u (.*);

// *** bench/rsevb_host.sv ***
// Purpose: host side issuing single reads
// Assumes: called just after a rising edge
// Notes: leaves one idle cycle after each read
`timescale 1ns/10ps
module rsevb_host (
   input wire logic mclk,
   output logic rd_en,
   output logic [6:0] rd_addr,
   input wire logic [7:0] rd_data
);
   initial
   begin
      rd_en = 1'b0;
      rd_addr = 7'h7f;
   end
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      rd_en = 1'b1;
      rd_addr = a;
      @(posedge mclk);
      #1;
      d = rd_data;
      rd_en = 1'b0;
      // released address shows junk, not the old value
      rd_addr = ~a;
      @(posedge mclk);
      #1;
   endtask
endmodule

// *** hw/rsevb_bank.sv ***
// Purpose: read-side register bank with live status, sticky events and data words
// Assumes: serial framing decodes reads into rd_en/rd_addr; producers on mclk
// Notes: read data registered, valid one cycle after rd_en
`timescale 1ns/10ps
`include "rsevb_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] status word A bits 0..5: rx word ready, tx buffer free, tx aborted or arbitration lost, encoder active, reverse control channel busy, counter at zero.
// [R2] status word A bits 7:6 carry the tone band code, 00 meaning invalid tone.
// [R3] status word B bits 0..2: audio interface active, voice message receiving, control frame sync.
// [R4] the event register holds twelve sticky flags and a read clears them.
// [R5] event bits 0..6 record rx ready, tx free, arbitration fail, tx done, busy change, counter zero, tone result change.
// [R6] event bits 7..11 record audio done, dotting, voice sync, control sync change, periodic tone update.
// [R7] events latch regardless of any interrupt enables.
// [R8] port status reads give the synchronised pin levels, 8, 8 and 4 bits.
// [R9] corrected word bits 27..4 read high byte first at 0x10..0x12.
// [R10] 0x13 holds corrected bits 3..0 above the 4-bit decode status.
// [R11] the 40-bit raw word reads highest byte first at 0x18..0x1c.
// [R12] 0x1d reports the 4-bit majority vote repeat count.
// [R13] 0x20 returns the 8-bit audio converter result.
// [R14] 0x30 returns the tone offset from 6 kHz, two's complement, 1 Hz per step.
// [R15] an event in the cycle of an event read stays set for the next read.
// [R16] unlisted addresses and unused upper bits read as zero.
module rsevb_bank #(
   parameter int PORT_A_W = 8,
   parameter int PORT_B_W = 8,
   parameter int PORT_C_W = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic rd_en,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic rx_word_ready,
   input wire logic tx_buffer_free,
   input wire logic tx_abort_or_arb_lost,
   input wire logic tx_encoder_active,
   input wire logic reverse_control_channel_busy,
   input wire logic counter_at_zero,
   input wire rsevb_pkg::rsevb_band_type supervisory_tone_band,
   input wire logic audio_if_active,
   input wire logic forward_voice_channel_receiving,
   input wire logic forward_control_channel_sync,
   input wire logic [`RSEVB_EVENT_COUNT-1:0] event_pulse,
   input wire logic [PORT_A_W-1:0] expansion_port_a_pins,
   input wire logic [PORT_B_W-1:0] expansion_port_b_pins,
   input wire logic [PORT_C_W-1:0] expansion_port_c_pins,
   input wire logic [27:0] corrected_rx_word,
   input wire logic [3:0] decode_status,
   input wire logic [39:0] raw_rx_word,
   input wire logic [3:0] vote_repeats,
   input wire logic [7:0] audio_adc_value,
   input wire logic [7:0] supervisory_tone_offset
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [PORT_A_W-1:0] port_a_q;
   logic [PORT_B_W-1:0] port_b_q;
   logic [PORT_C_W-1:0] port_c_q;

   rsevb_sync #(.WIDTH(PORT_A_W)) u_sync_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(expansion_port_a_pins),
      .sync_out(port_a_q)
   );
   rsevb_sync #(.WIDTH(PORT_B_W)) u_sync_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(expansion_port_b_pins),
      .sync_out(port_b_q)
   );
   rsevb_sync #(.WIDTH(PORT_C_W)) u_sync_c (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(expansion_port_c_pins),
      .sync_out(port_c_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sticky events
   logic [`RSEVB_EVENT_COUNT-1:0] events_q;
   logic [`RSEVB_EVENT_COUNT-1:0] events_d;
   logic events_read;

   assign events_read = rd_en && (rd_addr == `RSEVB_ADDR_EVENTS);

   // no enable gating here; masking belongs to the interrupt path
   always_comb
   begin
      events_d = events_q;
      if (events_read)
      begin
         events_d = '0; // [R4]
      end
      events_d = events_d | event_pulse; // [R5] [R6] [R7] [R15]
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         events_q <= `RSEVB_EVENTS_RESET;
      end
      else
      begin
         events_q <= events_d; // [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   logic [7:0] status_a;
   logic [7:0] status_b;
   logic [7:0] rd_data_d;

   always_comb
   begin
      status_a = 8'h00;
      status_a[0] = rx_word_ready; // [R1]
      status_a[1] = tx_buffer_free; // [R1]
      status_a[2] = tx_abort_or_arb_lost; // [R1]
      status_a[3] = tx_encoder_active; // [R1]
      status_a[4] = reverse_control_channel_busy; // [R1]
      status_a[5] = counter_at_zero; // [R1]
      status_a[`RSEVB_BAND_LSB+:2] = supervisory_tone_band; // [R2]
      status_b = {5'h00, forward_control_channel_sync, forward_voice_channel_receiving,
                  audio_if_active}; // [R3]
   end

   // event register wider than the data path: low byte at offset, high nibble not mapped
   always_comb
   begin
      rd_data_d = 8'h00; // [R16]
      case (rd_addr)
         `RSEVB_ADDR_STATUS_A: rd_data_d = status_a;
         `RSEVB_ADDR_STATUS_B: rd_data_d = status_b;
         `RSEVB_ADDR_EVENTS: rd_data_d = events_q[7:0]; // [R4]
         `RSEVB_ADDR_PORT_A: rd_data_d = 8'(port_a_q); // [R8]
         `RSEVB_ADDR_PORT_B: rd_data_d = 8'(port_b_q); // [R8]
         `RSEVB_ADDR_PORT_C: rd_data_d = 8'(port_c_q); // [R8] [R16]
         `RSEVB_ADDR_CRX0: rd_data_d = corrected_rx_word[27:20]; // [R9]
         `RSEVB_ADDR_CRX1: rd_data_d = corrected_rx_word[19:12]; // [R9]
         `RSEVB_ADDR_CRX2: rd_data_d = corrected_rx_word[11:4]; // [R9]
         `RSEVB_ADDR_CRX3: rd_data_d = {corrected_rx_word[3:0], decode_status}; // [R10]
         `RSEVB_ADDR_RAW0: rd_data_d = raw_rx_word[39:32]; // [R11]
         `RSEVB_ADDR_RAW1: rd_data_d = raw_rx_word[31:24]; // [R11]
         `RSEVB_ADDR_RAW2: rd_data_d = raw_rx_word[23:16]; // [R11]
         `RSEVB_ADDR_RAW3: rd_data_d = raw_rx_word[15:8]; // [R11]
         `RSEVB_ADDR_RAW4: rd_data_d = raw_rx_word[7:0]; // [R11]
         `RSEVB_ADDR_REPEAT: rd_data_d = {4'h0, vote_repeats}; // [R12]
         `RSEVB_ADDR_ADC: rd_data_d = audio_adc_value; // [R13]
         `RSEVB_ADDR_TONE: rd_data_d = supervisory_tone_offset; // [R14]
         default: rd_data_d = 8'h00; // [R16]
      endcase
   end

   // held between reads so the serial shifter can take it at leisure
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data <= 8'h00;
      end
      else if (rd_en)
      begin
         rd_data <= rd_data_d;
      end
   end
endmodule

// *** hw/rsevb_sync.sv ***
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to mclk
// Notes: first stage read only by the second
`timescale 1ns/10ps
module rsevb_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** inc/rsevb_defines.svh ***
// Purpose: offsets, field positions and timing counts of the readback bank
// Assumes: 7-bit read addresses, 8-bit read data
// Notes: included by bare name
`ifndef RSEVB_DEFINES_SVH
`define RSEVB_DEFINES_SVH
`define RSEVB_ADDR_STATUS_A 7'h00
`define RSEVB_ADDR_STATUS_B 7'h01
`define RSEVB_ADDR_EVENTS 7'h02
`define RSEVB_ADDR_PORT_A 7'h04
`define RSEVB_ADDR_PORT_B 7'h05
`define RSEVB_ADDR_PORT_C 7'h06
`define RSEVB_ADDR_CRX0 7'h10
`define RSEVB_ADDR_CRX1 7'h11
`define RSEVB_ADDR_CRX2 7'h12
`define RSEVB_ADDR_CRX3 7'h13
`define RSEVB_ADDR_RAW0 7'h18
`define RSEVB_ADDR_RAW1 7'h19
`define RSEVB_ADDR_RAW2 7'h1a
`define RSEVB_ADDR_RAW3 7'h1b
`define RSEVB_ADDR_RAW4 7'h1c
`define RSEVB_ADDR_REPEAT 7'h1d
`define RSEVB_ADDR_ADC 7'h20
`define RSEVB_ADDR_TONE 7'h30
`define RSEVB_EVENT_COUNT 12
`define RSEVB_EVENTS_RESET 12'h000
`define RSEVB_BAND_LSB 6
`define RSEVB_TONE_UPDATE_S 0.2
`endif

// *** inc/rsevb_pkg.sv ***
// Purpose: types of the readback bank
// Assumes: nothing
// Notes: constants live in rsevb_defines.svh
package rsevb_pkg;
   typedef enum logic [1:0] {
      rsevb_band_invalid,
      rsevb_band_low,
      rsevb_band_mid,
      rsevb_band_high
   } rsevb_band_type;
endpackage
